/* rtl/emb_pkg.sv */
package emb_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock and processor cycle timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TCK_PS        = 16000;
  localparam int CK_CYCLES     = TCK_PS / CLK_PERIOD_PS;
  localparam int HALF_CK       = CK_CYCLES / 2;
  localparam int QTR_CK        = CK_CYCLES / 4;
  localparam int CKI_CYCLES    = 2 * CK_CYCLES;

  localparam int PH_W          = 2;
  localparam logic [PH_W-1:0] PH_ACCEPT = 2'h3;
  localparam logic [PH_W-1:0] PH_STROBE = 2'h1;

  // Access sizes and reset values
  localparam int ADDR_W        = 14;
  localparam int DATA_W        = 24;
  localparam int WAIT_W        = 3;
  localparam int CNT_W         = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;

  typedef enum logic [2:0] {
    SPACE_PROGRAM,
    SPACE_DATA,
    SPACE_COMPOSITE,
    SPACE_IO,
    SPACE_BYTE
  } emb_space_t;

  typedef struct packed {
    logic program_space_sel_n;
    logic data_space_sel_n;
    logic composite_space_sel_n;
    logic io_space_sel_n;
    logic byte_space_sel_n;
  } emb_sel_t;

  localparam emb_sel_t SEL_IDLE = 5'h1f;

  typedef struct packed {
    logic              write;
    emb_space_t        space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [WAIT_W-1:0] waits;
  } emb_req_t;

  typedef enum {ACC_IDLE, ACC_SETUP, ACC_STROBE, ACC_HOLD} emb_acc_st_t;
  typedef enum {BUS_OWN, BUS_FLOAT, BUS_GRANTED, BUS_RETURN} emb_bus_st_t;

endpackage

/* rtl/emb_bus.sv */
module emb_bus #(
  parameter int DATA_W = emb_pkg::DATA_W
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      req_valid,
  input  wire emb_pkg::emb_req_t         req,
  output logic                           req_taken,
  output logic                           rsp_valid,
  output logic [DATA_W-1:0]              rsp_rdata,
  input  wire logic                      core_bus_need,
  input  wire logic                      dma_bus_need,
  output logic                           proc_clock_out,
  output logic                           in_clock_ref,
  input  wire logic                      ext_bus_req_n,
  output logic                           ext_bus_gnt_n,
  output logic                           grant_hang_n,
  output emb_pkg::emb_sel_t              space_select_group,
  output logic                           rd_strobe_n,
  output logic                           wr_strobe_n,
  output logic                           strobe_oe_n,
  output logic [emb_pkg::ADDR_W-1:0]     addr_out,
  output logic [DATA_W-1:0]              data_out,
  output logic                           data_oe_n,
  input  wire logic [DATA_W-1:0]         data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  function automatic emb_pkg::emb_sel_t sel_of(input emb_pkg::emb_space_t s);
    emb_pkg::emb_sel_t r;
    r = emb_pkg::SEL_IDLE;
    case (s)
      emb_pkg::SPACE_PROGRAM:   r.program_space_sel_n   = 1'b0;
      emb_pkg::SPACE_DATA:      r.data_space_sel_n      = 1'b0;
      emb_pkg::SPACE_COMPOSITE: r.composite_space_sel_n = 1'b0;
      emb_pkg::SPACE_IO:        r.io_space_sel_n        = 1'b0;
      default:                  r.byte_space_sel_n      = 1'b0;
    endcase
    return r;
  endfunction

  // Processor cycle phase and clock outputs
  logic [emb_pkg::PH_W-1:0] phase_q, phase_d;
  logic                     pclk_q, pclk_d;
  logic                     iclk_q, iclk_d;

  always_comb begin
    phase_d = phase_q + 2'h1;
    pclk_d  = (phase_d < emb_pkg::PH_W'(emb_pkg::HALF_CK));
    iclk_d  = (phase_d == '0) ? ~iclk_q : iclk_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= '1;
      pclk_q  <= 1'b0;
      iclk_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      pclk_q  <= pclk_d;
      iclk_q  <= iclk_d;
    end
  end

  // Pin synchronisers
  logic              breq_s1_q, breq_s2_q;
  logic [DATA_W-1:0] din_s1_q, din_s2_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      breq_s1_q <= 1'b1;
      breq_s2_q <= 1'b1;
      din_s1_q  <= '0;
      din_s2_q  <= '0;
    end else begin
      breq_s1_q <= ext_bus_req_n;
      breq_s2_q <= breq_s1_q;
      din_s1_q  <= data_in;
      din_s2_q  <= din_s1_q;
    end
  end

  // Access sequencer and bus hand-over
  emb_pkg::emb_acc_st_t     acc_q, acc_d;
  emb_pkg::emb_bus_st_t     bus_q, bus_d;
  logic [emb_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic                     wr_q, wr_d;
  logic [emb_pkg::ADDR_W-1:0] addr_q, addr_d;
  emb_pkg::emb_sel_t        sel_q, sel_d;
  logic                     rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic [DATA_W-1:0]        dout_q, dout_d, rdat_q, rdat_d;
  logic                     doe_n_q, doe_n_d, soe_n_q, soe_n_d;
  logic                     gnt_n_q, gnt_n_d, hang_n_q, hang_n_d;
  logic                     taken_q, taken_d, rsp_q, rsp_d;
  logic [emb_pkg::CNT_W-1:0] len_q, len_d;
  logic                     cycle_end;

  always_comb begin
    acc_d     = acc_q;
    bus_d     = bus_q;
    cnt_d     = cnt_q;
    wr_d      = wr_q;
    addr_d    = addr_q;
    sel_d     = sel_q;
    rd_n_d    = rd_n_q;
    wr_n_d    = wr_n_q;
    dout_d    = dout_q;
    rdat_d    = rdat_q;
    doe_n_d   = doe_n_q;
    soe_n_d   = soe_n_q;
    gnt_n_d   = gnt_n_q;
    hang_n_d  = hang_n_q;
    len_d     = len_q;
    taken_d   = 1'b0;
    rsp_d     = 1'b0;
    cycle_end = (phase_q == emb_pkg::PH_ACCEPT);
    case (acc_q)
      emb_pkg::ACC_IDLE: begin
        if (bus_q == emb_pkg::BUS_OWN && cycle_end && breq_s2_q &&
            req_valid) begin
          acc_d   = emb_pkg::ACC_SETUP;
          taken_d = 1'b1;
          wr_d    = req.write;
          addr_d  = req.addr;
          sel_d   = sel_of(req.space);
          dout_d  = req.wdata;
          len_d   = emb_pkg::CNT_W'(emb_pkg::HALF_CK) +
                    emb_pkg::CNT_W'(req.waits) *
                    emb_pkg::CNT_W'(emb_pkg::CK_CYCLES);
        end
      end
      emb_pkg::ACC_SETUP: begin
        acc_d = emb_pkg::ACC_STROBE;
        cnt_d = len_q - 8'h01;
        if (wr_q) begin
          wr_n_d  = 1'b0;
          doe_n_d = 1'b0;
        end else begin
          rd_n_d  = 1'b0;
        end
      end
      emb_pkg::ACC_STROBE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == '0) begin
          acc_d  = emb_pkg::ACC_HOLD;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
        end
      end
      emb_pkg::ACC_HOLD: begin
        acc_d   = emb_pkg::ACC_IDLE;
        sel_d   = emb_pkg::SEL_IDLE;
        doe_n_d = 1'b1;
        rsp_d   = 1'b1;
        if (!wr_q) begin
          rdat_d = din_s2_q;
        end
      end
      default: acc_d = emb_pkg::ACC_IDLE;
    endcase
    case (bus_q)
      emb_pkg::BUS_OWN: begin
        if (acc_q == emb_pkg::ACC_IDLE && cycle_end && !breq_s2_q) begin
          bus_d   = emb_pkg::BUS_FLOAT;
          soe_n_d = 1'b1;
        end
      end
      emb_pkg::BUS_FLOAT: begin
        bus_d   = emb_pkg::BUS_GRANTED;
        gnt_n_d = 1'b0;
      end
      emb_pkg::BUS_GRANTED: begin
        if (breq_s2_q) begin
          bus_d    = emb_pkg::BUS_RETURN;
          gnt_n_d  = 1'b1;
          hang_n_d = 1'b1;
        end else begin
          hang_n_d = ~(core_bus_need | dma_bus_need);
        end
      end
      emb_pkg::BUS_RETURN: begin
        bus_d   = emb_pkg::BUS_OWN;
        soe_n_d = 1'b0;
      end
      default: bus_d = emb_pkg::BUS_OWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q    <= emb_pkg::ACC_IDLE;
      bus_q    <= emb_pkg::BUS_OWN;
      cnt_q    <= '0;
      len_q    <= '0;
      wr_q     <= 1'b0;
      addr_q   <= emb_pkg::ADDR_RST;
      sel_q    <= emb_pkg::SEL_IDLE;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
      dout_q   <= '0;
      rdat_q   <= '0;
      doe_n_q  <= 1'b1;
      soe_n_q  <= 1'b0;
      gnt_n_q  <= 1'b1;
      hang_n_q <= 1'b1;
      taken_q  <= 1'b0;
      rsp_q    <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      bus_q    <= bus_d;
      cnt_q    <= cnt_d;
      len_q    <= len_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      sel_q    <= sel_d;
      rd_n_q   <= rd_n_d;
      wr_n_q   <= wr_n_d;
      dout_q   <= dout_d;
      rdat_q   <= rdat_d;
      doe_n_q  <= doe_n_d;
      soe_n_q  <= soe_n_d;
      gnt_n_q  <= gnt_n_d;
      hang_n_q <= hang_n_d;
      taken_q  <= taken_d;
      rsp_q    <= rsp_d;
    end
  end

  assign proc_clock_out     = pclk_q;
  assign in_clock_ref       = iclk_q;
  assign req_taken          = taken_q;
  assign rsp_valid          = rsp_q;
  assign rsp_rdata          = rdat_q;
  assign ext_bus_gnt_n      = gnt_n_q;
  assign grant_hang_n       = hang_n_q;
  assign space_select_group = sel_q;
  assign rd_strobe_n        = rd_n_q;
  assign wr_strobe_n        = wr_n_q;
  assign strobe_oe_n        = soe_n_q;
  assign addr_out           = addr_q;
  assign data_out           = dout_q;
  assign data_oe_n          = doe_n_q;

  // Strobe width helper
  logic [emb_pkg::CNT_W-1:0] low_cnt_q;

  always_ff @(posedge clk) begin
    if (srst || (rd_n_q && wr_n_q)) begin
      low_cnt_q <= '0;
    end else begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  float_first_a: assert property (@(posedge clk) disable iff (srst)
    $fell(gnt_n_q) |-> soe_n_q && $past(soe_n_q))
    else $error("Grant went low while strobes still driven");

  grant_first_a: assert property (@(posedge clk) disable iff (srst)
    $fell(soe_n_q) |-> gnt_n_q && $past(gnt_n_q))
    else $error("Strobes driven before grant returned high");

  hang_order_a: assert property (@(posedge clk) disable iff (srst)
    !hang_n_q |-> soe_n_q && $past(soe_n_q) && !gnt_n_q)
    else $error("Grant hang low while strobes driven");

  hang_need_a: assert property (@(posedge clk) disable iff (srst)
    (bus_q == emb_pkg::BUS_GRANTED && !breq_s2_q &&
     (core_bus_need || dma_bus_need)) |=> !hang_n_q)
    else $error("Grant hang not asserted on bus need");

  strobe_width_a: assert property (@(posedge clk) disable iff (srst)
    ($rose(rd_n_q) || $rose(wr_n_q)) |-> low_cnt_q == len_q)
    else $error("Strobe width differs from programmed length");

  rd_quarter_a: assert property (@(posedge clk) disable iff (srst)
    $fell(rd_n_q) |-> phase_q == emb_pkg::PH_STROBE && $past(pclk_q))
    else $error("Read strobe not a quarter cycle after clock rise");

  wr_quarter_a: assert property (@(posedge clk) disable iff (srst)
    $fell(wr_n_q) |-> phase_q == emb_pkg::PH_STROBE && $past(pclk_q))
    else $error("Write strobe not a quarter cycle after clock rise");

  strobe_gap_a: assert property (@(posedge clk) disable iff (srst)
    ($rose(rd_n_q) || $rose(wr_n_q)) |=> rd_n_q && wr_n_q)
    else $error("Strobe fell again within half a cycle");

  data_enable_a: assert property (@(posedge clk) disable iff (srst)
    $fell(doe_n_q) |-> $fell(wr_n_q))
    else $error("Write data driven away from strobe fall");

  data_float_a: assert property (@(posedge clk) disable iff (srst)
    ($fell(rd_n_q) || $fell(wr_n_q)) |-> $past(doe_n_q))
    else $error("Write data still driven before strobe fell");

  addr_stable_a: assert property (@(posedge clk) disable iff (srst)
    (!rd_n_q || !wr_n_q) |=> $stable(addr_q) && $stable(sel_q)
      && sel_q != emb_pkg::SEL_IDLE)
    else $error("Address or select moved around strobe");

  clk_ratio_a: assert property (@(posedge clk) disable iff (srst)
    $rose(pclk_q) |-> ##4 $rose(pclk_q))
    else $error("Clock output period wrong");

  ref_period_a: assert property (@(posedge clk) disable iff (srst)
    $rose(iclk_q) |-> ##8 ($rose(iclk_q) && $rose(pclk_q)))
    else $error("Input clock reference not at half the output rate");

  idle_high_a: assert property (@(posedge clk) disable iff (srst)
    (acc_q == emb_pkg::ACC_IDLE && bus_q == emb_pkg::BUS_OWN) |->
      sel_q == emb_pkg::SEL_IDLE && rd_n_q && wr_n_q)
    else $error("Select or strobe active while idle");

  req_act_a: assert property (@(posedge clk) disable iff (srst)
    (bus_q == emb_pkg::BUS_OWN && acc_q == emb_pkg::ACC_IDLE &&
     !ext_bus_req_n) [*8] |-> bus_q != emb_pkg::BUS_OWN)
    else $error("Bus request not acted on within two cycles");

endmodule

/* tb/emb_mem_model.sv */
module emb_mem_model (
  input  wire logic              rd_strobe_n,
  input  wire logic              wr_strobe_n,
  input  wire logic              data_oe_n,
  input  wire emb_pkg::emb_sel_t sel,
  input  wire logic [13:0]       addr,
  input  wire logic [23:0]       data_out,
  output logic [23:0]            data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [0:524287];
  logic [23:0] last;
  initial last = 24'h00_0000;
  // Word captured when the write strobe is released
  always @(posedge wr_strobe_n) begin
    if (data_oe_n === 1'b0) mem[{sel, addr}] = data_out;
  end
  // Remember the word read, for the changed pattern after release
  always @(posedge rd_strobe_n) begin
    last = mem[{sel, addr}];
  end
  // Valid data only while read strobe low, else a changed pattern
  assign data_in = (rd_strobe_n === 1'b0) ? mem[{sel, addr}] : ~last;
endmodule

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, req_valid, core_bus_need, dma_bus_need, ext_bus_req_n;
  emb_pkg::emb_req_t req;
  logic req_taken, rsp_valid, proc_clock_out, in_clock_ref;
  logic ext_bus_gnt_n, grant_hang_n, rd_strobe_n, wr_strobe_n, strobe_oe_n;
  logic data_oe_n;
  logic [23:0] rsp_rdata, data_out, data_in, exp_d;
  logic [13:0] addr_out, exp_a;
  emb_pkg::emb_sel_t space_select_group, exp_sel;
  int n_errors, checks, exp_w, waited, low, gap, pco_age, pco_per, icr_per;
  logic busy, mon_on, exp_rd, prev_st, prev_oe, prev_pco, prev_icr, strb;

  emb_bus dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_taken(req_taken), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .core_bus_need(core_bus_need), .dma_bus_need(dma_bus_need),
    .proc_clock_out(proc_clock_out), .in_clock_ref(in_clock_ref),
    .ext_bus_req_n(ext_bus_req_n), .ext_bus_gnt_n(ext_bus_gnt_n),
    .grant_hang_n(grant_hang_n), .space_select_group(space_select_group),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .strobe_oe_n(strobe_oe_n), .addr_out(addr_out), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in));
  emb_mem_model u_mem (.rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .data_oe_n(data_oe_n), .sel(space_select_group), .addr(addr_out),
    .data_out(data_out), .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_sig(input int k);
    for (waited = 1; waited < 200; waited++) begin
      @(negedge clk);
      if ((k == 0 && req_taken === 1'b1) || (k == 1 && rsp_valid === 1'b1)
          || (k == 2 && strobe_oe_n === 1'b1)
          || (k == 3 && ext_bus_gnt_n === 1'b1)) return;
    end
    n_errors++;
    report_and_stop();
  endtask

  task automatic start(input logic w, input int sp, input logic [13:0] a,
                       input logic [23:0] d, input logic [2:0] ws);
    @(negedge clk);
    busy = 1'b1;
    exp_w = 2 + 4 * ws;
    exp_sel = emb_pkg::SEL_IDLE & ~(5'h10 >> sp);
    exp_a = a;
    exp_d = d;
    exp_rd = !w;
    req = '{write: w, space: emb_pkg::emb_space_t'(sp), addr: a,
            wdata: d, waits: ws};
    req_valid = 1'b1;
  endtask

  task automatic finish_acc();
    wait_sig(0);
    req_valid = 1'b0;
    wait_sig(1);
    busy = 1'b0;
    if (exp_rd) chk(rsp_rdata, exp_d);
  endtask

  task automatic spaces_rw();
    for (int sp = 0; sp < 5; sp++) begin
      start(1'b1, sp, 14'h0100 + 14'(sp), 24'ha5_0000 + 24'(sp),
            (sp == 4) ? 3'h7 : 3'(sp));
      finish_acc();
    end
    for (int sp = 0; sp < 5; sp++) begin
      start(1'b0, sp, 14'h0100 + 14'(sp), 24'ha5_0000 + 24'(sp), 3'h0);
      finish_acc();
    end
    start(1'b1, 1, 14'h3fff, 24'h5a_c3c3, 3'h1);
    finish_acc();
    start(1'b0, 1, 14'h3fff, 24'h5a_c3c3, 3'h1);
    finish_acc();
  endtask

  task automatic grant_seq();
    @(negedge clk);
    ext_bus_req_n = 1'b0;
    wait_sig(2);
    chk(waited <= emb_pkg::CK_CYCLES + 3, 1);
    chk(ext_bus_gnt_n, 1);
    @(negedge clk);
    chk(ext_bus_gnt_n, 0);
    chk(grant_hang_n, 1);
    start(1'b0, 1, 14'h0101, 24'ha5_0001, 3'h0);
    core_bus_need = 1'b1;
    repeat (3) @(negedge clk);
    chk(grant_hang_n, 0);
    chk(strobe_oe_n, 1);
    core_bus_need = 1'b0;
    dma_bus_need = 1'b1;
    repeat (3) @(negedge clk);
    chk(grant_hang_n, 0);
    dma_bus_need = 1'b0;
    repeat (3) @(negedge clk);
    chk(grant_hang_n, 1);
    core_bus_need = 1'b1;
    repeat (3) @(negedge clk);
    ext_bus_req_n = 1'b1;
    wait_sig(3);
    chk(grant_hang_n, 1);
    chk(strobe_oe_n, 1);
    @(negedge clk);
    chk(strobe_oe_n, 0);
    core_bus_need = 1'b0;
    finish_acc();
  endtask

  // Pin timing monitor
  always @(negedge clk) begin
    strb = rd_strobe_n & wr_strobe_n;
    if (mon_on) begin
      if (prev_st === 1'b1 && strb === 1'b0) begin
        chk(gap >= emb_pkg::HALF_CK, 1);
        chk(pco_age, emb_pkg::QTR_CK);
        chk(prev_oe, 1);
        chk(space_select_group, exp_sel);
        chk(addr_out, exp_a);
        low = 0;
      end
      if (strb === 1'b0) low++;
      else gap++;
      if (prev_st === 1'b0 && strb === 1'b1) begin
        chk(low, exp_w);
        chk(space_select_group, exp_sel);
        gap = 1;
      end
      if (prev_oe === 1'b1 && data_oe_n === 1'b0) chk(wr_strobe_n, 0);
      if (prev_pco === 1'b0 && proc_clock_out === 1'b1) begin
        if (pco_per > 0) chk(pco_per, emb_pkg::CK_CYCLES);
        pco_per = 0;
        pco_age = 0;
      end
      if (prev_icr === 1'b0 && in_clock_ref === 1'b1) begin
        if (icr_per > 0) chk(icr_per, emb_pkg::CKI_CYCLES);
        icr_per = 0;
      end
      if (!busy && ext_bus_gnt_n === 1'b1 && strobe_oe_n === 1'b0)
        chk({space_select_group, strb}, {emb_pkg::SEL_IDLE, 1'b1});
      pco_per++;
      icr_per++;
      pco_age++;
    end
    prev_st = strb;
    prev_oe = data_oe_n;
    prev_pco = proc_clock_out;
    prev_icr = in_clock_ref;
  end

  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    core_bus_need = 1'b0;
    dma_bus_need = 1'b0;
    ext_bus_req_n = 1'b1;
    {n_errors, checks, low, pco_age} = '0;
    pco_per = -100;
    icr_per = -100;
    gap = 100;
    {busy, mon_on, exp_rd} = '0;
    repeat (16) @(negedge clk);
    chk({space_select_group, rd_strobe_n, wr_strobe_n, ext_bus_gnt_n},
        {emb_pkg::SEL_IDLE, 3'h7});
    srst = 1'b0;
    mon_on = 1'b1;
    spaces_rw();
    grant_seq();
    repeat (8) @(negedge clk);
    report_and_stop();
  end
endmodule
